// ### inc/gpio_port_pkg.sv
// Shared constants and types for the general-purpose I/O port block.
// Assumes an 8-bit register port with byte addresses and one system clock.
package gpio_port_pkg;

    // Register port widths.
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 8;

    // Implemented pins per port; port 5 holds only bits 1 and 0.
    localparam int WIDE_PORT_PINS  = 8;
    localparam int PORT5_PINS      = 2;
    localparam int TOTAL_PINS      = 26;

    // Register offsets as printed in the register map.
    localparam logic [7:0] PORT0_DATA_OFS      = 8'h80;
    localparam logic [7:0] PORT1_DATA_OFS      = 8'h90;
    localparam logic [7:0] PORT1_DIRECTION_OFS = 8'h91;
    localparam logic [7:0] PORT1_PULLUP_OFS    = 8'h92;
    localparam logic [7:0] PORT0_DIRECTION_OFS = 8'h9A;
    localparam logic [7:0] PORT0_PULLUP_OFS    = 8'h9B;
    localparam logic [7:0] PORT2_DATA_OFS      = 8'hA0;
    localparam logic [7:0] PORT2_DIRECTION_OFS = 8'hA1;
    localparam logic [7:0] PORT2_PULLUP_OFS    = 8'hA2;
    localparam logic [7:0] PORT5_DATA_OFS      = 8'hD8;
    localparam logic [7:0] PORT5_DIRECTION_OFS = 8'hD9;
    localparam logic [7:0] PORT5_PULLUP_OFS    = 8'hDA;

    // Reset values of the wide and the narrow registers.
    localparam logic [7:0] WIDE_RESET   = 8'h00;
    localparam logic [1:0] NARROW_RESET = 2'h0;

    // Answer on a read of an unmapped offset, and idle read data.
    localparam logic [7:0] IDLE_READ    = 8'h00;

    // Fill above the two implemented port 5 bits on reads.
    localparam logic [5:0] PORT5_UPPER_FILL = 6'h00;

    // Direction encoding of a pin: input or strong push-pull output.
    localparam logic DIR_INPUT  = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;

    // Pull-up encoding of a pin while it is an input.
    localparam logic PULL_OFF = 1'b0;
    localparam logic PULL_ON  = 1'b1;

    // One bit per implemented pin of every port plus eight pad bits above port 5, 34 in all.
    typedef struct packed {
        logic [7:0] p5_pad;
        logic [1:0] p5;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } pins_raw_type;

    // Compact bundle carrying one bit for each of the 26 pins.
    typedef struct packed {
        logic [1:0] p5;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } pins_type;

endpackage

// ### src/general_purpose_io_ports.sv
// General-purpose I/O port logic for 26 pins in ports 0, 1, 2 and 5.
// Assumes a pad ring outside that applies output, enable and pull-up
// to each pin and returns the pin's level asynchronously.
// Software reaches the registers over a plain byte-wide port; read data
// stand one cycle after the read strobe and read as zero otherwise.
//
// What this block does
// - Twenty-six pins, each an input or an output under register control.
// - Direction bit 0 selects input, 1 selects strong push-pull output.
// - Pull-up bit 1 enables the pull-up, only while the pin is input.
// - Reset clears every direction and pull-up bit: floating inputs.
// - Reading a data register returns the live pin level for outputs.
// - A pulled-up input reads high unless pulled low from outside.
// - Port 5 implements only bits 1 and 0 in all its registers.
// - Port 0 and port 1 data registers are 8-bit, reset to zero.
// - Port 2 data is 8-bit reset zero; port 5 data has two bits.

`timescale 1ns/1ps
`default_nettype none

module general_purpose_io_ports
    import gpio_port_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [DATA_WIDTH-1:0] reg_rdata,
    input  wire pins_type              pin_in,
    output var  pins_type              pin_out,
    output var  pins_type              pin_oe,
    output var  pins_type              pin_pullup_en
);

    // Compares the register port address with one register offset.
    function automatic logic offset_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [7:0]            ofs
    );
        offset_hit = (addr == ofs);
    endfunction

    // A pull-up is applied only to a pin that is an input.
    function automatic logic [7:0] pull_gate(
        input logic [7:0] pull_bits,
        input logic [7:0] dir_bits
    );
        pull_gate = pull_bits & ~dir_bits;
    endfunction

    // The same gating for the two implemented port 5 pins.
    function automatic logic [PORT5_PINS-1:0] pull_gate_narrow(
        input logic [PORT5_PINS-1:0] pull_bits,
        input logic [PORT5_PINS-1:0] dir_bits
    );
        pull_gate_narrow = pull_bits & ~dir_bits;
    endfunction

    // Stored output latches, direction bits and pull-up bits.
    pins_type      data_reg;
    wire pins_type data_next;
    pins_type      dir_reg;
    wire pins_type dir_next;
    pins_type      pull_reg;
    wire pins_type pull_next;

    // Registered pad controls.
    pins_type      pull_en_reg;
    wire pins_type pull_en_next;

    // Two-stage synchroniser for the asynchronous pin levels.
    pins_type sync1_reg;
    pins_type sync2_reg;

    // Read data register and its next value.
    logic [DATA_WIDTH-1:0] rdata_reg;
    logic [DATA_WIDTH-1:0] rdata_next;

    // Address decode of every mapped offset.
    wire logic hit_p0_data;
    wire logic hit_p0_dir;
    wire logic hit_p0_pull;
    wire logic hit_p1_data;
    wire logic hit_p1_dir;
    wire logic hit_p1_pull;
    wire logic hit_p2_data;
    wire logic hit_p2_dir;
    wire logic hit_p2_pull;
    wire logic hit_p5_data;
    wire logic hit_p5_dir;
    wire logic hit_p5_pull;

    assign hit_p0_data = offset_hit(reg_addr, PORT0_DATA_OFS);
    assign hit_p0_dir  = offset_hit(reg_addr, PORT0_DIRECTION_OFS);
    assign hit_p0_pull = offset_hit(reg_addr, PORT0_PULLUP_OFS);

    // Decode of the port 1 offsets.
    assign hit_p1_data = offset_hit(reg_addr, PORT1_DATA_OFS);
    assign hit_p1_dir  = offset_hit(reg_addr, PORT1_DIRECTION_OFS);
    assign hit_p1_pull = offset_hit(reg_addr, PORT1_PULLUP_OFS);

    // Decode of the port 2 offsets.
    assign hit_p2_data = offset_hit(reg_addr, PORT2_DATA_OFS);
    assign hit_p2_dir  = offset_hit(reg_addr, PORT2_DIRECTION_OFS);
    assign hit_p2_pull = offset_hit(reg_addr, PORT2_PULLUP_OFS);

    // Decode of the port 5 offsets.
    assign hit_p5_data = offset_hit(reg_addr, PORT5_DATA_OFS);
    assign hit_p5_dir  = offset_hit(reg_addr, PORT5_DIRECTION_OFS);
    assign hit_p5_pull = offset_hit(reg_addr, PORT5_PULLUP_OFS);

    // Write strobes qualified by the decode.
    wire logic wr_p0_data;
    wire logic wr_p0_dir;
    wire logic wr_p0_pull;
    wire logic wr_p1_data;
    wire logic wr_p1_dir;
    wire logic wr_p1_pull;
    wire logic wr_p2_data;
    wire logic wr_p2_dir;
    wire logic wr_p2_pull;
    wire logic wr_p5_data;
    wire logic wr_p5_dir;
    wire logic wr_p5_pull;

    assign wr_p0_data = reg_wr & hit_p0_data;
    assign wr_p0_dir  = reg_wr & hit_p0_dir;
    assign wr_p0_pull = reg_wr & hit_p0_pull;

    // Write strobes of the port 1 registers.
    assign wr_p1_data = reg_wr & hit_p1_data;
    assign wr_p1_dir  = reg_wr & hit_p1_dir;
    assign wr_p1_pull = reg_wr & hit_p1_pull;

    // Write strobes of the port 2 registers.
    assign wr_p2_data = reg_wr & hit_p2_data;
    assign wr_p2_dir  = reg_wr & hit_p2_dir;
    assign wr_p2_pull = reg_wr & hit_p2_pull;

    // Write strobes of the port 5 registers.
    assign wr_p5_data = reg_wr & hit_p5_data;
    assign wr_p5_dir  = reg_wr & hit_p5_dir;
    assign wr_p5_pull = reg_wr & hit_p5_pull;

    // The two implemented port 5 bits of the write data.
    wire logic [PORT5_PINS-1:0] wdata_p5;

    assign wdata_p5 = reg_wdata[PORT5_PINS-1:0];

    // Output latches take a write regardless of direction.
    assign data_next.p0 = wr_p0_data ? reg_wdata : data_reg.p0;
    assign data_next.p1 = wr_p1_data ? reg_wdata : data_reg.p1;
    assign data_next.p2 = wr_p2_data ? reg_wdata : data_reg.p2;
    assign data_next.p5 = wr_p5_data ? wdata_p5  : data_reg.p5;

    // Direction bits: 0 input, 1 push-pull output.
    assign dir_next.p0 = wr_p0_dir ? reg_wdata : dir_reg.p0;
    assign dir_next.p1 = wr_p1_dir ? reg_wdata : dir_reg.p1;
    assign dir_next.p2 = wr_p2_dir ? reg_wdata : dir_reg.p2;
    assign dir_next.p5 = wr_p5_dir ? wdata_p5  : dir_reg.p5;

    // Pull-up select bits, stored as written.
    assign pull_next.p0 = wr_p0_pull ? reg_wdata : pull_reg.p0;
    assign pull_next.p1 = wr_p1_pull ? reg_wdata : pull_reg.p1;
    assign pull_next.p2 = wr_p2_pull ? reg_wdata : pull_reg.p2;
    assign pull_next.p5 = wr_p5_pull ? wdata_p5  : pull_reg.p5;

    // The pad pull-up is on only for a selected pin that is an input.
    assign pull_en_next.p0 = pull_gate(pull_next.p0, dir_next.p0);
    assign pull_en_next.p1 = pull_gate(pull_next.p1, dir_next.p1);
    assign pull_en_next.p2 = pull_gate(pull_next.p2, dir_next.p2);
    assign pull_en_next.p5 =
        pull_gate_narrow(pull_next.p5, dir_next.p5);

    // Read selection; data offsets return the synchronised pin levels,
    // so an output reads its real level and a pulled-up input reads high
    // until something outside pulls it down.
    wire logic [DATA_WIDTH-1:0] read_p0_data;
    wire logic [DATA_WIDTH-1:0] read_p1_data;
    wire logic [DATA_WIDTH-1:0] read_p2_data;
    wire logic [DATA_WIDTH-1:0] read_p5_data;

    assign read_p0_data = sync2_reg.p0;
    assign read_p1_data = sync2_reg.p1;
    assign read_p2_data = sync2_reg.p2;
    assign read_p5_data = {PORT5_UPPER_FILL, sync2_reg.p5};

    // Readback of the stored direction bits.
    wire logic [DATA_WIDTH-1:0] read_p0_dir;
    wire logic [DATA_WIDTH-1:0] read_p1_dir;
    wire logic [DATA_WIDTH-1:0] read_p2_dir;
    wire logic [DATA_WIDTH-1:0] read_p5_dir;

    assign read_p0_dir  = dir_reg.p0;
    assign read_p1_dir  = dir_reg.p1;
    assign read_p2_dir  = dir_reg.p2;
    assign read_p5_dir  = {PORT5_UPPER_FILL, dir_reg.p5};

    // Readback of the stored pull-up select bits.
    wire logic [DATA_WIDTH-1:0] read_p0_pull;
    wire logic [DATA_WIDTH-1:0] read_p1_pull;
    wire logic [DATA_WIDTH-1:0] read_p2_pull;
    wire logic [DATA_WIDTH-1:0] read_p5_pull;

    assign read_p0_pull = pull_reg.p0;
    assign read_p1_pull = pull_reg.p1;
    assign read_p2_pull = pull_reg.p2;
    assign read_p5_pull = {PORT5_UPPER_FILL, pull_reg.p5};

    // Kind of register that the address selects.
    wire logic hit_data;
    wire logic hit_dir;
    wire logic hit_pull;

    assign hit_data = hit_p0_data | hit_p1_data | hit_p2_data | hit_p5_data;
    assign hit_dir  = hit_p0_dir | hit_p1_dir | hit_p2_dir | hit_p5_dir;
    assign hit_pull = hit_p0_pull | hit_p1_pull | hit_p2_pull | hit_p5_pull;

    // Selection among the four ports within each kind of register.
    wire logic [DATA_WIDTH-1:0] sel_data;
    wire logic [DATA_WIDTH-1:0] sel_dir;
    wire logic [DATA_WIDTH-1:0] sel_pull;

    assign sel_data =
        hit_p0_data ? read_p0_data :
        hit_p1_data ? read_p1_data :
        hit_p2_data ? read_p2_data :
                      read_p5_data;

    assign sel_dir =
        hit_p0_dir ? read_p0_dir :
        hit_p1_dir ? read_p1_dir :
        hit_p2_dir ? read_p2_dir :
                     read_p5_dir;

    assign sel_pull =
        hit_p0_pull ? read_p0_pull :
        hit_p1_pull ? read_p1_pull :
        hit_p2_pull ? read_p2_pull :
                      read_p5_pull;

    // Final selection; an unmapped offset reads as the idle value.
    wire logic [DATA_WIDTH-1:0] read_mux;

    assign read_mux =
        hit_data ? sel_data :
        hit_dir  ? sel_dir  :
        hit_pull ? sel_pull :
                   IDLE_READ;

    // Read data stand only in the cycle after the read strobe.
    assign rdata_next = reg_rd ? read_mux : IDLE_READ;

    // Output latches clear at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= '{p5: NARROW_RESET,
                          p2: WIDE_RESET,
                          p1: WIDE_RESET,
                          p0: WIDE_RESET};
        end else begin
            data_reg <= data_next;
        end
    end

    // Direction bits clear at reset, so every pin starts as an input.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= '{p5: NARROW_RESET,
                         p2: WIDE_RESET,
                         p1: WIDE_RESET,
                         p0: WIDE_RESET};
        end else begin
            dir_reg <= dir_next;
        end
    end

    // Pull-up select bits clear at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_reg <= '{p5: NARROW_RESET,
                          p2: WIDE_RESET,
                          p1: WIDE_RESET,
                          p0: WIDE_RESET};
        end else begin
            pull_reg <= pull_next;
        end
    end

    // Pad pull-ups start off, so inputs start high-impedance.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_en_reg <= '{p5: NARROW_RESET,
                             p2: WIDE_RESET,
                             p1: WIDE_RESET,
                             p0: WIDE_RESET};
        end else begin
            pull_en_reg <= pull_en_next;
        end
    end

    // First synchroniser stage; only the second stage reads it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '{p5: NARROW_RESET,
                           p2: WIDE_RESET,
                           p1: WIDE_RESET,
                           p0: WIDE_RESET};
        end else begin
            sync1_reg <= pin_in;
        end
    end

    // Second synchroniser stage, the only source of pin levels for reads.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync2_reg <= '{p5: NARROW_RESET,
                           p2: WIDE_RESET,
                           p1: WIDE_RESET,
                           p0: WIDE_RESET};
        end else begin
            sync2_reg <= sync1_reg;
        end
    end

    // Registered read answer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= IDLE_READ;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Pad drive: the latch is driven while the direction is output.
    assign pin_out       = data_reg;
    assign pin_oe        = dir_reg;
    assign pin_pullup_en = pull_en_reg;

    // Read data reach the port straight from their register.
    assign reg_rdata     = rdata_reg;

endmodule // general_purpose_io_ports

`default_nettype wire

// ### tb/board_pins.sv
// Board-side model of the 26 port pins: resolves each wire's level.
// Assumes the bench says which pins an outside source drives, and to what.
`timescale 1ns/1ps
`default_nettype none
module board_pins
    import gpio_port_pkg::*;
(
    input  wire logic     clk,
    input  wire pins_type pin_out,
    input  wire pins_type pin_oe,
    input  wire pins_type pin_pullup_en,
    input  wire pins_type ext_en,
    input  wire pins_type ext_val,
    output var  pins_type pin_in
);
    // Floating pins wander every cycle so that a floating read can match on alternate cycles at most.
    logic [25:0] noise_reg = 26'h2AAAAAA;
    always @(posedge clk) noise_reg <= ~noise_reg;
    // Push-pull output wins, then an outside source, then the pull-up.
    assign pin_in = (pin_oe & pin_out)
        | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pin_pullup_en)
        | (~pin_oe & ~ext_en & ~pin_pullup_en & noise_reg);
endmodule // board_pins
`default_nettype wire

// ### tb/gpio_port_properties.sv
// Checker for the I/O port block, watching the top module's ports only.
// Assumes one-cycle read data and a two-stage pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_properties
    import gpio_port_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [DATA_WIDTH-1:0] reg_rdata,
    input wire pins_type              pin_in,
    input wire pins_type              pin_out,
    input wire pins_type              pin_oe,
    input wire pins_type              pin_pullup_en
);
    // Counts edges since release so the pin sampler is known to be full.
    logic [1:0] age_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
    // Decodes a write to any direction register.
    wire logic dir_wr = reg_wr && (reg_addr == PORT0_DIRECTION_OFS ||
        reg_addr == PORT1_DIRECTION_OFS || reg_addr == PORT2_DIRECTION_OFS ||
        reg_addr == PORT5_DIRECTION_OFS);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_dir_write: assert property (
        reg_wr && reg_addr == PORT0_DIRECTION_OFS
        |=> pin_oe.p0 == $past(reg_wdata))
        else $error("direction write lost");
    a_oe_stable: assert property (!dir_wr |=> $stable(pin_oe))
        else $error("output enable moved without a write");
    a_pull_masked: assert property (
        (pin_oe & pin_pullup_en) == 26'h0)
        else $error("pull-up on while driving");
    a_pull_write: assert property (
        reg_wr && reg_addr == PORT0_PULLUP_OFS
        |=> pin_pullup_en.p0 == ($past(reg_wdata) & ~pin_oe.p0))
        else $error("pull-up write lost");
    a_data_write: assert property (
        reg_wr && reg_addr == PORT1_DATA_OFS
        |=> pin_out.p1 == $past(reg_wdata))
        else $error("data latch wrong");
    a_live_read: assert property (
        age_reg == 2'h3 && reg_rd && reg_addr == PORT2_DATA_OFS
        |=> reg_rdata == $past(pin_in.p2, 3))
        else $error("data read is not the pin level");
    a_p5_narrow: assert property (
        reg_wr && reg_addr == PORT5_DIRECTION_OFS
        |=> pin_oe.p5 == $past(reg_wdata[1:0])
        ##1 ($past(dir_wr) || pin_oe.p5 == $past(pin_oe.p5)))
        else $error("port 5 direction wrong");
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_dir_read: assert property (
        reg_rd && reg_addr == PORT1_DIRECTION_OFS
        |=> reg_rdata == pin_oe.p1)
        else $error("direction readback wrong");
endmodule // gpio_port_properties
bind general_purpose_io_ports gpio_port_properties chk (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en));
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the I/O port block with a board-side pin model.
// Assumes one-cycle read data and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tb
    import gpio_port_pkg::*;
;
    logic       clk, rst_n, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    pins_type   pin_in, pin_out, pin_oe, pin_pullup_en, ext_en, ext_val;
    int         errors, n_checks;
    logic [7:0] sh [3][4];
    // Offsets, owning port and kind (0 data, 1 direction, 2 pull-up, 3 none).
    logic [7:0] ofs [13] = '{PORT0_DATA_OFS, PORT1_DATA_OFS,
        PORT1_DIRECTION_OFS, PORT1_PULLUP_OFS, PORT0_DIRECTION_OFS,
        PORT0_PULLUP_OFS, PORT2_DATA_OFS, PORT2_DIRECTION_OFS,
        PORT2_PULLUP_OFS, PORT5_DATA_OFS, PORT5_DIRECTION_OFS,
        PORT5_PULLUP_OFS, 8'h93};
    int         prt [13] = '{0, 1, 1, 1, 0, 0, 2, 2, 2, 3, 3, 3, 0};
    int         knd [13] = '{0, 0, 1, 2, 1, 2, 0, 1, 2, 0, 1, 2, 3};
    general_purpose_io_ports uut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));
    board_pins board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
    function automatic logic [7:0] msk(int p);
        return (p == 3) ? 8'h03 : 8'hFF;
    endfunction
    function automatic logic [7:0] pick(pins_type v, int p);
        case (p)
            0: return v.p0;
            1: return v.p1;
            2: return v.p2;
            default: return {6'h00, v.p5};
        endcase
    endfunction
    // Packs one kind of shadow into pin order; pull-ups only on inputs.
    function automatic pins_type pack(int k);
        logic [7:0] b [4];
        for (int p = 0; p < 4; p++)
            b[p] = (k == 2) ? sh[2][p] & ~sh[1][p] : sh[k][p];
        return {b[3][1:0], b[2], b[1], b[0]};
    endfunction
    // Expected read: stored byte, or the resolved pin level for data.
    function automatic logic [7:0] expect_rd(int i);
        int p;
        logic [7:0] oe;
        p = prt[i];
        oe = sh[1][p];
        if (knd[i] == 3) return 8'h00;
        if (knd[i] != 0) return sh[knd[i]][p];
        return msk(p) & ((oe & sh[0][p]) | (~oe & pick(ext_en, p) &
            pick(ext_val, p)) | (~oe & ~pick(ext_en, p) & sh[2][p]));
    endfunction
    task automatic check(logic [25:0] seen, logic [25:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register writes leave the strobe up so a read may follow at once.
    task automatic wr(int i, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= ofs[i];
        reg_wdata <= d;
        if (knd[i] < 3) sh[knd[i]][prt[i]] = d & msk(prt[i]);
    endtask
    task automatic rd(int i);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ofs[i];
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(26'(reg_rdata), 26'(expect_rd(i)));
    endtask
    task automatic idle(int n);
        repeat (n) begin
            @(posedge clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
    endtask
    task automatic pins_ok();
        check(pin_oe, pack(1));
        check(pin_out, pack(0));
        check(pin_pullup_en, pack(2));
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Reset, register map walk, corners, random traffic, second reset.
    initial begin
        int i;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        ext_en = '1;
        ext_val = '0;
        errors = 0;
        n_checks = 0;
        foreach (sh[k, p]) sh[k][p] = 8'h00;
        void'($urandom(32'h9AB41DA6));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        idle(3);
        pins_ok();
        for (int n = 0; n < 13; n++) rd(n);
        wr(7, 8'h5A);
        rd(7);
        wr(10, 8'hFF);
        rd(10);
        for (int n = 0; n < 80; n++) begin
            i = $urandom_range(12);
            wr(i, 8'($urandom));
            ext_val <= 26'($urandom);
            ext_en <= (26'($urandom) & ~pack(1)) | (~pack(1) & ~pack(2));
            idle(3);
            pins_ok();
            rd(i);
            rd($urandom_range(12));
        end
        rst_n <= 1'b0;
        ext_en <= '1;
        idle(2);
        rst_n <= 1'b1;
        foreach (sh[k, p]) sh[k][p] = 8'h00;
        idle(3);
        pins_ok();
        foreach (knd[n]) if (knd[n] == 1) wr(n, 8'hFF);
        idle(2);
        check(pin_oe, 26'h3FFFFFF);
        summarize();
    end
endmodule // tb
`default_nettype wire
